// ==== logic/watchdog_pkg.sv ====
// constants shared by the watchdog / interval timer design
`default_nettype none
package watchdog_pkg;
    // ***************************************************************
    // register addresses (lower 16 bits)
    // ***************************************************************
    localparam logic [15:0] addr_tcs_write    = 16'hffbc;  // count and control share it
    localparam logic [15:0] addr_tcs_read     = 16'hffbc;
    localparam logic [15:0] addr_count_read   = 16'hffbd;
    localparam logic [15:0] addr_rstcs_write  = 16'hffbe;
    localparam logic [15:0] addr_rstcs_read   = 16'hffbf;

    // ***************************************************************
    // password keys in the upper byte of a word write
    // ***************************************************************
    localparam logic [7:0] key_count   = 8'h5a;  // counter, or reset enable/select
    localparam logic [7:0] key_control = 8'ha5;  // control, or watchdog flag clear
    localparam logic [7:0] flag_clear_data = 8'h00;

    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int ovf_bit   = 7;
    localparam int mode_bit  = 6;
    localparam int tme_bit   = 5;
    localparam int cks_lsb   = 0;
    localparam int watchdog_overflow_flag_bit  = 7;
    localparam int reset_on_overflow_enable_bit  = 6;
    localparam int reset_type_select_bit  = 5;

    // ***************************************************************
    // reset values
    // ***************************************************************
    localparam logic [7:0] tcs_reset     = 8'h18;
    localparam logic [7:0] count_reset   = 8'h00;
    localparam logic [7:0] rstcs_reset   = 8'h1f;
    localparam logic [1:0] tcs_fixed     = 2'b11;    // bits 4 and 3
    localparam logic [4:0] rstcs_fixed   = 5'b11111; // bits 4 to 0
    localparam logic [2:0] cks_reset     = 3'h0;
    localparam logic [7:0] count_wrap    = 8'hff;

    // ***************************************************************
    // prescaler: divider bits that must be all ones for each tap
    // ***************************************************************
    localparam int div_width = 17;  // 131072 = 2**17
    localparam logic [4:0] tap_bits [8] = '{5'h01, 5'h06, 5'h07, 5'h09,
                                            5'h0b, 5'h0d, 5'h0f, 5'h11};

    // ***************************************************************
    // timing: one state is one mclk period (25 MHz, 40 ns)
    // ***************************************************************
    localparam int states_per_cycle    = 1;
    localparam int ovf_states_reset_on_overflow_enable     = 132;
    localparam int ovf_states_no_reset_on_overflow_enable  = 130;
    localparam int int_reset_states    = 518;
    localparam logic [9:0] ovf_cycles_reset_on_overflow_enable    = 10'(ovf_states_reset_on_overflow_enable / states_per_cycle);
    localparam logic [9:0] ovf_cycles_no_reset_on_overflow_enable = 10'(ovf_states_no_reset_on_overflow_enable / states_per_cycle);
    localparam logic [9:0] int_reset_cycles   = 10'(int_reset_states / states_per_cycle);
endpackage
`default_nettype wire

// ==== logic/prescale_if.sv ====
// carrier between the timer core and its clock prescaler
`default_nettype none
interface prescale_if;
    logic [2:0] select;  // clock select code
    logic       tick;    // one-cycle tap event
    modport source (input select, output tick);
    modport sink   (output select, input tick);
endinterface
`default_nettype wire

// ==== logic/prescaler.sv ====
// free-running divider of the system clock with eight selectable taps
`default_nettype none
module prescaler
    import watchdog_pkg::*;
(
    input  wire logic   mclk,
    input  wire logic   srst,
    prescale_if.source  pre
);
    logic [div_width-1:0] divider;
    logic [div_width-1:0] tap_mask;
    logic [div_width-1:0] next_divider;

    // ***************************************************************
    // tap decode
    // ***************************************************************
    // free-running tap events
    assign tap_mask     = div_width'((18'h1 << tap_bits[pre.select]) - 18'h1);
    assign next_divider = divider + 17'h1;

    // divider runs from reset on; a tap fires when its low bits wrap
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            divider  <= '0;
            pre.tick <= 1'b0;
        end
        else
        begin
            divider  <= next_divider;
            pre.tick <= ((divider & tap_mask) == tap_mask);
        end
    end
endmodule // prescaler
`default_nettype wire

// ==== logic/watchdog_unit.sv ====
// watchdog / interval timer core with password-protected registers
//
// Behaviour
// - 8-bit counter counts selected ticks when enabled
// - rollover: overflow pin or interval interrupt
// - counter cleared by reset, hardware standby, enable off
// - control register resets to 18 hex
// - interval flag set only in interval mode
// - flag clears on 0 write after read-1
// - bit 6 selects interval or watchdog mode
// - bit 5 enables counting, reset value 0
// - control bits 4 and 3 read 1
// - three select bits pick eight divide ratios
// - shared write address, separate read addresses
// - overflow pin driven only in watchdog mode
// - optional power-on or manual chip reset
// - only password writes accepted
// - reset-control resets to 1f, bit7 write-0 only
// - word write, key selects counter or control
// - reset-control keys: flag clear or enable/select
// - reset-control fields and reserved ones
// - pin low 132/130 states, reset 518
`default_nettype none
module watchdog_unit
    import watchdog_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        hw_standby,
    input  wire logic        sw_standby,
    input  wire logic [15:0] bus_addr,
    input  wire logic [15:0] bus_wdata,
    input  wire logic        bus_write,
    input  wire logic        bus_word,
    input  wire logic        bus_read,
    output logic      [7:0]  bus_rdata,
    output logic             overflow_output_n,
    output logic             interval_interrupt_request,
    output logic             internal_reset,
    output logic             internal_reset_manual
);
    // ***************************************************************
    // state
    // ***************************************************************
    logic [7:0] timer_count;
    logic       interval_overflow_flag;
    logic       mode_select;
    logic       timer_enable;
    logic [2:0] clock_select;
    logic       watchdog_overflow_flag;
    logic       reset_on_overflow_enable;
    logic       reset_type_select;
    logic       ovf_read_one;   // interval flag was read as 1
    logic       watchdog_overflow_flag_read_one;  // watchdog flag was read as 1
    logic [9:0] pin_count;
    logic [9:0] reset_count;

    prescale_if pre_link ();

    prescaler u_prescaler
    (
        .mclk (mclk),
        .srst (srst),
        .pre  (pre_link.source)
    );

    // ***************************************************************
    // address and password decode
    // ***************************************************************
    logic [7:0] key;
    logic [7:0] wbyte;
    logic       word_wr;
    logic       wr_count;
    logic       wr_control;
    logic       wr_watchdog_overflow_flag_clear;
    logic       wr_rst_fields;
    logic       rd_control;
    logic       rd_count;
    logic       rd_rstcs;

    assign key   = bus_wdata[15:8];
    assign wbyte = bus_wdata[7:0];
    assign word_wr = bus_write && bus_word;
    assign wr_count      = word_wr && bus_addr == addr_tcs_write && key == key_count;
    assign wr_control    = word_wr && bus_addr == addr_tcs_write && key == key_control;
    assign wr_watchdog_overflow_flag_clear = word_wr && bus_addr == addr_rstcs_write && key == key_control
                           && wbyte == flag_clear_data;
    assign wr_rst_fields = word_wr && bus_addr == addr_rstcs_write && key == key_count;
    assign rd_control = bus_read && bus_addr == addr_tcs_read;
    assign rd_count   = bus_read && bus_addr == addr_count_read;
    assign rd_rstcs   = bus_read && bus_addr == addr_rstcs_read;

    // ***************************************************************
    // register images
    // ***************************************************************
    logic [7:0] tcs_value;
    logic [7:0] rstcs_value;
    logic [7:0] next_rdata;

    assign tcs_value   = {interval_overflow_flag, mode_select, timer_enable,
                          tcs_fixed, clock_select};
    // reset-control layout, low bits read 1
    assign rstcs_value = {watchdog_overflow_flag, reset_on_overflow_enable,
                          reset_type_select, rstcs_fixed};
    // unmapped reads return zero
    assign next_rdata  = rd_control ? tcs_value :
                         rd_count   ? timer_count :
                         rd_rstcs   ? rstcs_value : 8'h00;

    // ***************************************************************
    // counting and overflow detection
    // ***************************************************************
    logic       count_step;
    logic       rollover;
    logic       next_enable;
    logic [7:0] next_count;

    assign pre_link.select = clock_select;
    // software standby freezes the count but keeps it
    assign count_step = timer_enable && pre_link.tick && !sw_standby;
    assign rollover   = count_step && timer_count == count_wrap && !wr_count;
    assign next_enable = wr_control ? wbyte[tme_bit] : timer_enable;
    // enable off holds counter at zero
    assign next_count = !next_enable ? count_reset :
                        wr_count     ? wbyte :
                        count_step   ? timer_count + 8'h01 : timer_count;

    // ***************************************************************
    // flag clear qualification
    // ***************************************************************
    logic ovf_set;
    logic ovf_clear;
    logic watchdog_overflow_flag_set;
    logic watchdog_overflow_flag_clear;

    assign ovf_set    = rollover && !mode_select;
    // clear needs a prior read of 1, write 1 ignored
    assign ovf_clear  = wr_control && !wbyte[ovf_bit] && ovf_read_one;
    assign watchdog_overflow_flag_set   = rollover && mode_select;
    assign watchdog_overflow_flag_clear = wr_watchdog_overflow_flag_clear && watchdog_overflow_flag_read_one;

    // counter and control: cleared by chip reset and hardware standby
    always_ff @(posedge mclk)
    begin
        if (srst || hw_standby)
        begin
            timer_count            <= count_reset;
            interval_overflow_flag <= tcs_reset[ovf_bit];
            mode_select            <= tcs_reset[mode_bit];
            timer_enable           <= tcs_reset[tme_bit];
            clock_select           <= cks_reset;
            ovf_read_one           <= 1'b0;
        end
        else
        begin
            timer_count <= next_count;
            interval_overflow_flag <= ovf_set | (interval_overflow_flag & ~ovf_clear);
            if (wr_control)
            begin
                mode_select  <= wbyte[mode_bit];
                timer_enable <= wbyte[tme_bit];
                clock_select <= wbyte[cks_lsb +: 3];
            end
            if (wr_control)
                ovf_read_one <= 1'b0;
            else if (rd_control && interval_overflow_flag)
                ovf_read_one <= 1'b1;
        end
    end

    // reset-control register: only the chip reset initialises it
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            watchdog_overflow_flag   <= rstcs_reset[watchdog_overflow_flag_bit];
            reset_on_overflow_enable <= rstcs_reset[reset_on_overflow_enable_bit];
            reset_type_select        <= rstcs_reset[reset_type_select_bit];
            watchdog_overflow_flag_read_one            <= 1'b0;
        end
        else
        begin
            // set on watchdog rollover, set wins
            watchdog_overflow_flag <= watchdog_overflow_flag_set | (watchdog_overflow_flag & ~watchdog_overflow_flag_clear);
            if (wr_rst_fields)
            begin
                reset_on_overflow_enable <= wbyte[reset_on_overflow_enable_bit];
                reset_type_select        <= wbyte[reset_type_select_bit];
            end
            if (wr_watchdog_overflow_flag_clear)
                watchdog_overflow_flag_read_one <= 1'b0;
            else if (rd_rstcs && watchdog_overflow_flag)
                watchdog_overflow_flag_read_one <= 1'b1;
        end
    end

    // ***************************************************************
    // pulse generation
    // ***************************************************************
    logic [9:0] pin_len;
    logic       fire_reset;

    // pin width depends on reset enable
    assign pin_len    = reset_on_overflow_enable ? ovf_cycles_reset_on_overflow_enable : ovf_cycles_no_reset_on_overflow_enable;
    assign fire_reset = watchdog_overflow_flag_set && reset_on_overflow_enable;

    // pulse counters; hardware standby cuts a pulse short
    always_ff @(posedge mclk)
    begin
        if (srst || hw_standby)
        begin
            pin_count             <= 10'h000;
            reset_count           <= 10'h000;
            overflow_output_n     <= 1'b1;
            internal_reset        <= 1'b0;
            internal_reset_manual <= 1'b0;
        end
        else
        begin
            // pin driven only on watchdog rollover
            if (watchdog_overflow_flag_set)
                pin_count <= pin_len - 10'h001;
            else if (pin_count != 10'h000)
                pin_count <= pin_count - 10'h001;
            overflow_output_n <= !(watchdog_overflow_flag_set || pin_count != 10'h000);
            if (fire_reset)
                reset_count <= int_reset_cycles - 10'h001;
            else if (reset_count != 10'h000)
                reset_count <= reset_count - 10'h001;
            internal_reset <= fire_reset || reset_count != 10'h000;
            if (fire_reset)
                internal_reset_manual <= reset_type_select;
        end
    end

    // ***************************************************************
    // read port and interrupt
    // ***************************************************************
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            bus_rdata                  <= 8'h00;
            interval_interrupt_request <= 1'b0;
        end
        else
        begin
            bus_rdata <= next_rdata;
            interval_interrupt_request <= interval_overflow_flag && !mode_select;
        end
    end
endmodule // watchdog_unit
`default_nettype wire

// ==== testbench/watchdog_unit_checker.sv ====
// port-level assertions for the watchdog / interval timer
`default_nettype none
module watchdog_unit_checker
    import watchdog_pkg::*;
(
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        hw_standby,
    input wire logic        sw_standby,
    input wire logic [15:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic        bus_write,
    input wire logic        bus_word,
    input wire logic        bus_read,
    input wire logic [7:0]  bus_rdata,
    input wire logic        overflow_output_n,
    input wire logic        interval_interrupt_request,
    input wire logic        internal_reset,
    input wire logic        internal_reset_manual
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] low_cnt;  // cycles the pin has been low
    logic [9:0] rst_cnt;  // cycles the internal reset has been high
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // pulse widths; a retriggered pulse would run long, so runs keep overflows apart
    always_ff @(posedge mclk)
    begin
        low_cnt <= (srst || overflow_output_n) ? 10'h000 : low_cnt + 10'h001;
        rst_cnt <= (srst || !internal_reset) ? 10'h000 : rst_cnt + 10'h001;
    end
    rdata_idle_a: assert property (!bus_read |=> bus_rdata == 8'h00)
        else $error("read data not idle");
    ctrl_fixed_a: assert property (bus_read && bus_addr == addr_tcs_read
        |=> bus_rdata[4:3] == tcs_fixed) else $error("control bits 4:3 not set");
    rstcs_fixed_a: assert property (bus_read && bus_addr == addr_rstcs_read
        |=> bus_rdata[4:0] == rstcs_fixed) else $error("reset-control low bits not set");
    pin_width_a: assert property ($rose(overflow_output_n)
        |-> low_cnt == (internal_reset ? 10'd132 : 10'd130)) else $error("pin width");
    reset_width_a: assert property ($fell(internal_reset) |-> rst_cnt == 10'd518)
        else $error("internal reset width");
    reset_with_pin_a: assert property ($rose(internal_reset)
        |-> $fell(overflow_output_n)) else $error("reset without pin");
    irq_no_pin_a: assert property ($rose(interval_interrupt_request)
        |-> overflow_output_n) else $error("pin low on interval overflow");
    standby_quiet_a: assert property (hw_standby
        |=> overflow_output_n && !internal_reset) else $error("pulse in standby");
endmodule // watchdog_unit_checker
bind watchdog_unit watchdog_unit_checker u_watchdog_unit_checker (
    .mclk(mclk), .srst(srst), .hw_standby(hw_standby), .sw_standby(sw_standby),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
    .bus_word(bus_word), .bus_read(bus_read), .bus_rdata(bus_rdata),
    .overflow_output_n(overflow_output_n),
    .interval_interrupt_request(interval_interrupt_request),
    .internal_reset(internal_reset), .internal_reset_manual(internal_reset_manual)
);
`default_nettype wire

// ==== testbench/reset_monitor.sv ====
// model of the system reset circuit that watches the overflow pin
`default_nettype none
module reset_monitor
(
    input  wire logic        mclk,
    input  wire logic        overflow_output_n,
    input  wire logic        internal_reset,
    output var  logic [15:0] low_len,
    output var  logic [15:0] rst_len,
    output var  logic [15:0] rst_count
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] low_run = 16'h0000;
    logic [15:0] rst_run = 16'h0000;
    initial
    begin
        low_len = 16'h0000;
        rst_len = 16'h0000;
        rst_count = 16'h0000;
    end
    // lengths update only once a pulse has ended, as a real reset circuit sees them
    always @(posedge mclk)
    begin
        low_run <= overflow_output_n ? 16'h0000 : low_run + 16'h0001;
        if (overflow_output_n && low_run != 16'h0000)
            low_len <= low_run;
        rst_run <= internal_reset ? rst_run + 16'h0001 : 16'h0000;
        if (!internal_reset && rst_run != 16'h0000)
        begin
            rst_len <= rst_run;
            rst_count <= rst_count + 16'h0001;
        end
    end
endmodule // reset_monitor
`default_nettype wire

// ==== testbench/watchdog_unit_test.sv ====
// self-checking bench for the watchdog / interval timer
`default_nettype none
module watchdog_unit_test
    import watchdog_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, srst, hw_standby, sw_standby, bus_write, bus_word, bus_read;
    logic [15:0] bus_addr, bus_wdata, low_len, rst_len, rst_count;
    logic [7:0]  bus_rdata, rd_val;
    logic        overflow_output_n, interval_interrupt_request;
    logic        internal_reset, internal_reset_manual;
    logic        last_manual = 1'b0;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          ratio [6] = '{2, 64, 128, 512, 2048, 8192};

    watchdog_unit u_watchdog_unit (.mclk(mclk), .srst(srst), .hw_standby(hw_standby),
        .sw_standby(sw_standby), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_write(bus_write), .bus_word(bus_word), .bus_read(bus_read),
        .bus_rdata(bus_rdata), .overflow_output_n(overflow_output_n),
        .interval_interrupt_request(interval_interrupt_request),
        .internal_reset(internal_reset), .internal_reset_manual(internal_reset_manual));
    reset_monitor u_reset_monitor (.mclk(mclk), .overflow_output_n(overflow_output_n),
        .internal_reset(internal_reset), .low_len(low_len), .rst_len(rst_len),
        .rst_count(rst_count));

    // ****************************************************************
    // bus tasks: drive on a falling edge, one access, one idle cycle
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] addr, input logic [15:0] data, input logic word);
        bus_addr = addr;
        bus_wdata = data;
        bus_word = word;
        bus_write = 1'b1;
        @(negedge mclk);
        bus_write = 1'b0;
        @(negedge mclk);
    endtask
    task automatic rd(input logic [15:0] addr);
        bus_addr = addr;
        bus_read = 1'b1;
        @(negedge mclk);
        rd_val = bus_rdata;
        bus_read = 1'b0;
        @(negedge mclk);
    endtask
    task automatic rd_chk(input logic [15:0] addr, input logic [15:0] exp);
        rd(addr);
        check({8'h00, rd_val}, exp);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        rd_chk(addr_tcs_read, 16'h0018);
        rd_chk(addr_count_read, 16'h0000);
        rd_chk(addr_rstcs_read, 16'h001f);
        rd_chk(addr_rstcs_write, 16'h0000);
        wr(addr_tcs_write, {key_control, 8'h27}, 1'b0);
        rd_chk(addr_tcs_read, 16'h0018);
        wr(addr_tcs_write, 16'h3327, 1'b1);
        rd_chk(addr_tcs_read, 16'h0018);
        wr(addr_tcs_write, {key_count, 8'h7f}, 1'b1);
        rd_chk(addr_count_read, 16'h0000);
        wr(addr_tcs_write, {key_control, 8'hc7}, 1'b1);
        rd_chk(addr_tcs_read, 16'h005f);
        wr(addr_tcs_write, {key_control, 8'h00}, 1'b1);
    endtask
    task automatic t_flag();
        wr(addr_tcs_write, {key_control, 8'h20}, 1'b1);
        wr(addr_tcs_write, {key_count, 8'hfe}, 1'b1);
        for (int i = 0; i < 16 && !interval_interrupt_request; i++) @(negedge mclk);
        check(16'(interval_interrupt_request), 16'h0001);
        wr(addr_tcs_write, {key_control, 8'h20}, 1'b1);
        rd_chk(addr_tcs_read, 16'h00b8);
        rd_chk(addr_tcs_read, 16'h00b8);
        wr(addr_tcs_write, {key_control, 8'ha0}, 1'b1);
        rd_chk(addr_tcs_read, 16'h00b8);
        wr(addr_tcs_write, {key_control, 8'h00}, 1'b1);
        rd_chk(addr_tcs_read, 16'h0018);
        check(16'(interval_interrupt_request), 16'h0000);
    endtask
    // tick spacing is timed between the rollover and the next increment
    task automatic t_clocks();
        int n;
        for (int c = 0; c < 6; c++)
        begin
            wr(addr_tcs_write, {key_control, 8'h20 | 8'(c)}, 1'b1);
            wr(addr_tcs_write, {key_count, 8'hff}, 1'b1);
            for (int i = 0; i < 2 * ratio[c] + 8 && !interval_interrupt_request; i++)
                @(negedge mclk);
            n = 0;
            rd_val = 8'h00;
            while (rd_val !== 8'h01 && n < ratio[c] + 20)
            begin
                rd(addr_count_read);
                n += 2;
            end
            check(16'(n), 16'(ratio[c] + 2));
            rd_chk(addr_tcs_read, {8'h00, 8'hb8 | 8'(c)});
            wr(addr_tcs_write, {key_control, 8'h00}, 1'b1);
        end
    endtask
    task automatic wd_run(input logic [7:0] cfg);
        logic [15:0] resets;
        resets = rst_count;
        wr(addr_rstcs_write, {key_count, cfg}, 1'b1);
        wr(addr_tcs_write, {key_control, 8'h60}, 1'b1);
        wr(addr_tcs_write, {key_count, 8'hfe}, 1'b1);
        for (int i = 0; i < 16 && overflow_output_n; i++) @(negedge mclk);
        check(16'(overflow_output_n), 16'h0000);
        check(16'(interval_interrupt_request), 16'h0000);
        rd_chk(addr_tcs_read, 16'h0078);
        wr(addr_tcs_write, {key_control, 8'h40}, 1'b1);
        for (int i = 0; i < 200 && !overflow_output_n; i++) @(negedge mclk);
        for (int i = 0; i < 600 && internal_reset; i++) @(negedge mclk);
        repeat (2) @(negedge mclk);
        if (cfg[6])
            last_manual = cfg[5];
        check(low_len, cfg[6] ? 16'd132 : 16'd130);
        check(rst_count, resets + 16'(cfg[6]));
        check(rst_len, 16'd518);
        check(16'(internal_reset_manual), 16'(last_manual));
        rd_chk(addr_rstcs_read, {8'h00, 8'h9f | cfg});
        wr(addr_rstcs_write, {key_control, flag_clear_data}, 1'b1);
        rd_chk(addr_rstcs_read, {8'h00, 8'h1f | cfg});
    endtask
    task automatic t_standby();
        sw_standby = 1'b1;
        wr(addr_tcs_write, {key_control, 8'h20}, 1'b1);
        wr(addr_tcs_write, {key_count, 8'h40}, 1'b1);
        repeat (20) @(negedge mclk);
        rd_chk(addr_count_read, 16'h0040);
        rd_chk(addr_tcs_read, 16'h0038);
        sw_standby = 1'b0;
        hw_standby = 1'b1;
        @(negedge mclk);
        hw_standby = 1'b0;
        rd_chk(addr_tcs_read, 16'h0018);
        rd_chk(addr_count_read, 16'h0000);
        rd_chk(addr_rstcs_read, 16'h003f);
    endtask

    // ****************************************************************
    // clock, watchdog and main sequence
    // ****************************************************************
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // roughly three and a half times the expected run length
    initial
    begin
        #(40 * 60000);
        n_mismatch++;
        test_done();
    end
    initial
    begin
        srst = 1'b1;
        hw_standby = 1'b0;
        sw_standby = 1'b0;
        bus_addr = 16'h0000;
        bus_wdata = 16'h0000;
        bus_write = 1'b0;
        bus_word = 1'b0;
        bus_read = 1'b0;
        repeat (12) @(negedge mclk);
        srst = 1'b0;
        t_reset();
        t_flag();
        t_clocks();
        wd_run(8'h60);
        wd_run(8'h40);
        wd_run(8'h20);
        t_standby();
        test_done();
    end
endmodule // watchdog_unit_test
`default_nettype wire
